// [usart_pkg.sv]
/*
  shared constants of the clocked serial port: register indices, bit
  positions, frame lengths and receive state codes.
  assumes a 32-bit apb slave where byte address = 4 * register index.
*/
package usart_pkg;
  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam int       ADDR_W      = 10;
  localparam logic [7:0] IDX_INTCTL  = 8'h0b;
  localparam logic [7:0] IDX_PIRFLAG = 8'h0c;
  localparam logic [7:0] IDX_RXCTL   = 8'h18;
  localparam logic [7:0] IDX_TXBUF   = 8'h19;
  localparam logic [7:0] IDX_RXBUF   = 8'h1a;
  localparam logic [7:0] IDX_PIEN    = 8'h8c;
  localparam logic [7:0] IDX_TXCTL   = 8'h98;
  localparam logic [7:0] IDX_BAUD    = 8'h99;
  // ************************************************************
  // bit positions
  // ************************************************************
  localparam int B_CLKSRC      = 7;
  localparam int B_TXNINTH_EN  = 6;
  localparam int B_TXENABLE    = 5;
  localparam int B_SYNCMODE    = 4;
  localparam int B_HISPEED     = 2;
  localparam int B_PORTEN      = 7;
  localparam int B_RXNINTH_EN  = 6;
  localparam int B_SINGLE_RX   = 5;
  localparam int B_CONT_RX     = 4;
  localparam int B_ADDRDET     = 3;
  localparam int B_NINTH_VAL   = 0;
  localparam int B_RXREADY     = 5;
  localparam int B_TXEMPTY     = 4;
  // ************************************************************
  // reset values and frame lengths
  // ************************************************************
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE  = 4'h9;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_BITS  = 4'h4,
    RX_STOP  = 4'h8
  } rxst_t;
endpackage

// [baud_if.sv]
/*
  bundle between the port core and its baud generator.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface baud_if;
  logic       run;
  logic       restart;
  logic [7:0] divisor;
  logic       tick;
  modport gen  (input run, restart, divisor, output tick);
  modport user (output run, restart, divisor, input tick);
endinterface

// [baud_gen.sv]
/*
  baud generator: one tick every divisor+1 clocks while run is high.
  assumes run, restart and divisor come from logic on the same clock.
*/
`timescale 1ns/1ps
module baud_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  baud_if.gen      bus
);
  typedef struct packed {
    logic [7:0] cnt;
  } bstate_t;
  bstate_t q;
  bstate_t d;

  // held at the divisor when stopped, so the first tick is a full period away
  always_comb begin
    d = q;
    if (!bus.run || bus.restart) begin
      d.cnt = bus.divisor;
    end else if (q.cnt == 8'h00) begin
      d.cnt = bus.divisor;
    end else begin
      d.cnt = q.cnt - 8'h01;
    end
  end

  assign bus.tick = bus.run && !bus.restart && (q.cnt == 8'h00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // baud_gen

// [usart_sync_tx.sv]
/*
  clocked-master serial transmitter with a receive path that offers
  9-bit address detect on async frames only, behind an apb register slave.
  assumes apb from logic on clk; the data pin arrives asynchronously
  and is synchronised here; pins are resolved from the enables outside.
*/
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module usart_sync_tx #(
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // apb slave
  input  wire logic [usart_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output wire logic [31:0]                prdata,
  output wire logic                       pready,
  output wire logic                       pslverr,
  // shift clock pin
  output wire logic                       shiftClockOut,
  output wire logic                       shiftClockOe_n,
  // serial data pin
  input  wire logic                       serialDataIn,
  output wire logic                       serialDataOut,
  output wire logic                       serialDataOe_n,
  // interrupt requests
  output wire logic                       rxIrqReq,
  output wire logic                       txIrqReq
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(FIFO_DEPTH);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]                 intCtl;
    logic [7:0]                 pieReg;
    logic [7:0]                 pirOther;
    logic [7:0]                 baudDiv;
    logic                       clkSrc;
    logic                       txNinthEn;
    logic                       txEnable;
    logic                       syncMode;
    logic                       hiSpeed;
    logic                       txNinthVal;
    logic                       portEn;
    logic                       rxNinthEn;
    logic                       singleRx;
    logic                       contRx;
    logic                       addrDet;
    logic                       overrun;
    logic [7:0]                 txBuf;
    logic                       txFull;
    logic                       txEmptyFlag;
    logic [8:0]                 txShift;
    logic [3:0]                 txCnt;
    logic                       txBusy;
    logic                       shiftClk;
    logic                       dataOut;
    usart_pkg::rxst_t           rxState;
    logic [8:0]                 rxShift;
    logic [3:0]                 rxCnt;
    logic                       rxPhase;
    logic [FIFO_DEPTH-1:0][9:0] fifo;
    logic [CW-1:0]              fifoCnt;
    logic                       sync1;
    logic                       sync2;
    logic                       rxPrev;
    logic [7:0]                 rdata;
    logic                       rxIrq;
    logic                       txIrq;
  } state_t;

  state_t     q;
  state_t     d;
  logic [7:0] idx;
  logic       wrAcc;
  logic       rdAcc;
  logic       mapped;
  logic       wrTx;
  logic       popRx;
  logic       rxEn;
  logic       master;
  logic       txConn;
  logic       ckRun;
  logic       ckActive;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       load;
  logic       push;
  logic       restart;
  logic       ferrBit;
  logic       wordNinth;
  logic [7:0] wordData;
  logic [3:0] txLen;
  logic [3:0] rxLen;
  logic [7:0] rdVal;

  // ************************************************************
  // baud generator
  // ************************************************************
  baud_if bIf ();
  baud_gen uBaud (
    .clk (clk),
    .rst (rst),
    .bus (bIf.gen)
  );
  assign bIf.run     = q.txEnable || q.contRx || q.singleRx;
  assign bIf.restart = restart;
  assign bIf.divisor = q.baudDiv;
  assign tick        = bIf.tick;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d         = q;
    idx       = paddr[usart_pkg::ADDR_W-1:2];
    wrAcc     = psel && penable && pwrite;
    rdAcc     = psel && penable && !pwrite;
    wrTx      = wrAcc && (idx == usart_pkg::IDX_TXBUF);
    rxEn      = q.contRx || q.singleRx;
    master    = q.syncMode && q.portEn && q.clkSrc;
    txConn    = q.syncMode && q.portEn && q.txEnable && !rxEn;
    ckRun     = master && (q.txEnable || rxEn);
    ckActive  = (txConn && q.txBusy) || (master && rxEn && (q.rxState == usart_pkg::RX_BITS));
    rise      = tick && ckRun && !q.shiftClk;
    fall      = tick && ckRun && q.shiftClk;
    popRx     = rdAcc && (idx == usart_pkg::IDX_RXBUF) && (q.fifoCnt != '0);
    txLen     = q.txNinthEn ? usart_pkg::LEN_NINE : usart_pkg::LEN_EIGHT;
    rxLen     = q.rxNinthEn ? usart_pkg::LEN_NINE : usart_pkg::LEN_EIGHT;
    load      = 1'b0;
    push      = 1'b0;
    restart   = 1'b0;
    ferrBit   = 1'b0;
    // pin sync: only the second stage and its delayed copy rxPrev are ever looked at
    d.sync1   = serialDataIn;
    d.sync2   = q.sync1;
    d.rxPrev  = q.sync2;

    // shift clock idles low and toggles only while a word is on the line,
    // so a slave never clocks idle bits in
    if (!ckRun) begin
      d.shiftClk = 1'b0;
    end else if (tick && ckActive) begin
      d.shiftClk = !q.shiftClk;
    end

    // transmitter; while a receive is on it is frozen, not reset
    if (!q.txEnable) begin
      d.txBusy  = 1'b0;
      d.txCnt   = 4'h0;
      d.dataOut = 1'b0;
    end else if (txConn) begin
      if (rise && q.txBusy) begin
        if (q.txCnt != 4'h0) begin
          d.dataOut = q.txShift[0];
          d.txShift = q.txShift >> 1;
          d.txCnt   = q.txCnt - 4'h1;
        end else if (q.txFull) begin
          // back to back: next word's first bit on this same edge
          load      = 1'b1;
          d.dataOut = q.txBuf[0];
          d.txShift = {q.txNinthVal, q.txBuf} >> 1;
          d.txCnt   = txLen - 4'h1;
        end else begin
          d.txBusy   = 1'b0;
          d.shiftClk = 1'b0;
        end
      end else if (!q.txBusy && q.txFull) begin
        load      = 1'b1;
        d.txBusy  = 1'b1;
        d.txShift = {q.txNinthVal, q.txBuf};
        d.txCnt   = txLen;
      end
    end
    if (load) begin
      d.txFull      = 1'b0;
      d.txEmptyFlag = 1'b1;
    end
    if (q.txEnable && !q.txFull) begin
      d.txEmptyFlag = 1'b1;
    end

    // receiver: clocked single/continuous words, or async frames
    case (q.rxState)
      usart_pkg::RX_IDLE: begin
        if (q.syncMode && master && rxEn) begin
          d.rxState = usart_pkg::RX_BITS;
          d.rxCnt   = rxLen;
        end else if (!q.syncMode && q.portEn && q.contRx && q.rxPrev && !q.sync2) begin
          restart   = 1'b1;
          d.rxState = usart_pkg::RX_START;
        end
      end
      usart_pkg::RX_START: begin
        if (tick) begin
          d.rxPhase = 1'b0;
          d.rxCnt   = rxLen;
          d.rxState = q.sync2 ? usart_pkg::RX_IDLE : usart_pkg::RX_BITS;
        end
      end
      usart_pkg::RX_BITS: begin
        if (tick && !q.syncMode) begin
          d.rxPhase = !q.rxPhase;
        end
        // clocked mode samples on the falling shift clock
        if (q.syncMode ? fall : (tick && q.rxPhase)) begin
          d.rxShift = {q.sync2, q.rxShift[8:1]};
          d.rxCnt   = q.rxCnt - 4'h1;
          if (q.rxCnt == 4'h1) begin
            if (q.syncMode) begin
              push      = 1'b1;
              d.rxState = usart_pkg::RX_IDLE;
            end else begin
              d.rxState = usart_pkg::RX_STOP;
            end
          end
        end
      end
      usart_pkg::RX_STOP: begin
        if (tick) begin
          d.rxPhase = !q.rxPhase;
        end
        if (tick && q.rxPhase) begin
          push      = 1'b1;
          ferrBit   = !q.sync2;
          d.rxState = usart_pkg::RX_IDLE;
        end
      end
      default: begin
        d.rxState = usart_pkg::RX_IDLE;
      end
    endcase
    if (!rxEn || !q.portEn) begin
      d.rxState = usart_pkg::RX_IDLE;
    end
    if (push && q.syncMode && q.singleRx && !q.contRx) begin
      d.singleRx = 1'b0;
    end

    // assemble the word; 8-bit frames sit one place higher in the shifter
    wordNinth = q.rxNinthEn && d.rxShift[8];
    wordData  = q.rxNinthEn ? d.rxShift[7:0] : d.rxShift[8:1];
    if (!q.syncMode && q.rxNinthEn && q.addrDet && !wordNinth) begin
      push = 1'b0;
    end

    // pop before push so a read and an arrival in one cycle both count
    if (popRx) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        d.fifo[i] = q.fifo[i+1];
      end
      d.fifoCnt = q.fifoCnt - 1'b1;
    end
    if (push && !q.overrun) begin
      if (d.fifoCnt == FULL) begin
        d.overrun = 1'b1;
      end else begin
        d.fifo[d.fifoCnt] = {ferrBit, wordNinth, wordData};
        d.fifoCnt         = d.fifoCnt + 1'b1;
      end
    end
    if (!q.contRx) begin
      d.overrun = 1'b0;
    end

    // register writes
    if (wrAcc) begin
      if (idx == usart_pkg::IDX_INTCTL) begin
        d.intCtl = pwdata[7:0];
      end else if (idx == usart_pkg::IDX_PIRFLAG) begin
        d.pirOther = pwdata[7:0];
      end else if (idx == usart_pkg::IDX_RXCTL) begin
        d.portEn    = pwdata[usart_pkg::B_PORTEN];
        d.rxNinthEn = pwdata[usart_pkg::B_RXNINTH_EN];
        d.singleRx  = pwdata[usart_pkg::B_SINGLE_RX];
        d.contRx    = pwdata[usart_pkg::B_CONT_RX];
        d.addrDet   = pwdata[usart_pkg::B_ADDRDET];
      end else if (idx == usart_pkg::IDX_TXBUF) begin
        d.txBuf       = pwdata[7:0];
        d.txFull      = 1'b1;
        d.txEmptyFlag = 1'b0;
      end else if (idx == usart_pkg::IDX_PIEN) begin
        d.pieReg = pwdata[7:0];
      end else if (idx == usart_pkg::IDX_TXCTL) begin
        d.clkSrc     = pwdata[usart_pkg::B_CLKSRC];
        d.txNinthEn  = pwdata[usart_pkg::B_TXNINTH_EN];
        d.txEnable   = pwdata[usart_pkg::B_TXENABLE];
        d.syncMode   = pwdata[usart_pkg::B_SYNCMODE];
        d.hiSpeed    = pwdata[usart_pkg::B_HISPEED];
        d.txNinthVal = pwdata[usart_pkg::B_NINTH_VAL];
      end else if (idx == usart_pkg::IDX_BAUD) begin
        d.baudDiv = pwdata[7:0];
      end
    end

    // read data is latched in the setup cycle
    mapped = 1'b1;
    if (idx == usart_pkg::IDX_INTCTL) begin
      rdVal = q.intCtl;
    end else if (idx == usart_pkg::IDX_PIRFLAG) begin
      rdVal = {q.pirOther[7:6], q.fifoCnt != '0, q.txEmptyFlag, q.pirOther[3:0]};
    end else if (idx == usart_pkg::IDX_RXCTL) begin
      rdVal = {q.portEn, q.rxNinthEn, q.singleRx, q.contRx, q.addrDet,
               q.fifo[0][9], q.overrun, q.fifo[0][8]};
    end else if (idx == usart_pkg::IDX_TXBUF) begin
      rdVal = q.txBuf;
    end else if (idx == usart_pkg::IDX_RXBUF) begin
      rdVal = q.fifo[0][7:0];
    end else if (idx == usart_pkg::IDX_PIEN) begin
      rdVal = q.pieReg;
    end else if (idx == usart_pkg::IDX_TXCTL) begin
      rdVal = {q.clkSrc, q.txNinthEn, q.txEnable, q.syncMode, 1'b0,
               q.hiSpeed, !q.txBusy, q.txNinthVal};
    end else if (idx == usart_pkg::IDX_BAUD) begin
      rdVal = q.baudDiv;
    end else begin
      rdVal  = usart_pkg::RST_BYTE;
      mapped = 1'b0;
    end
    if (psel && !penable) begin
      d.rdata = rdVal;
    end

    d.rxIrq = (q.fifoCnt != '0) && q.pieReg[usart_pkg::B_RXREADY];
    d.txIrq = q.txEmptyFlag && q.pieReg[usart_pkg::B_TXEMPTY];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.rxState <= usart_pkg::RX_IDLE;
      q.sync1   <= 1'b1;
      q.sync2   <= 1'b1;
      q.rxPrev  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata         = {24'h000000, q.rdata};
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !mapped;
  assign shiftClockOut  = q.shiftClk;
  assign shiftClockOe_n = !ckRun;
  assign serialDataOut  = q.dataOut;
  assign serialDataOe_n = !txConn;
  assign rxIrqReq       = q.rxIrq;
  assign txIrqReq       = q.txIrq;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence sTxWrite;
    psel && penable && pwrite && (idx == usart_pkg::IDX_TXBUF);
  endsequence
  sequence sLastPop;
    popRx && (q.fifoCnt == 1) && !push;
  endsequence

  a_empty_write: assert property (@(posedge clk) disable iff (rst)
    sTxWrite |=> !q.txEmptyFlag && q.txFull)
    else $error("buffer write left empty flag set");
  a_empty_sticky: assert property (@(posedge clk) disable iff (rst)
    q.txEmptyFlag && !wrTx |=> q.txEmptyFlag)
    else $error("empty flag cleared without buffer write");
  a_load_empties: assert property (@(posedge clk) disable iff (rst)
    load && !wrTx |=> q.txEmptyFlag && !q.txFull && q.txBusy)
    else $error("load did not empty the buffer");
  a_reload_last: assert property (@(posedge clk) disable iff (rst)
    load && q.txBusy |-> (q.txCnt == 4'h0) && rise)
    else $error("shifter reloaded before last bit");
  a_ninth_cap: assert property (@(posedge clk) disable iff (rst)
    load && !q.txBusy |=> q.txShift[8] == $past(q.txNinthVal))
    else $error("ninth bit not captured at load");
  a_baud_hold: assert property (@(posedge clk) disable iff (rst)
    !(q.txEnable || q.contRx || q.singleRx) |-> !tick ##1 !q.shiftClk)
    else $error("baud generator ran while idle");
  a_half_duplex: assert property (@(posedge clk) disable iff (rst)
    !serialDataOe_n |-> !(q.contRx || q.singleRx) && q.txEnable)
    else $error("data driven during reception");
  a_tx_abort: assert property (@(posedge clk) disable iff (rst)
    $fell(q.txEnable) && !rxEn |-> serialDataOe_n && shiftClockOe_n ##1 !q.txBusy)
    else $error("pins driven after transmit abort");
  a_rx_keepclk: assert property (@(posedge clk) disable iff (rst)
    rxEn && master |-> !shiftClockOe_n && serialDataOe_n)
    else $error("clock released during master receive");
  a_single_clr: assert property (@(posedge clk) disable iff (rst)
    push && q.syncMode && q.singleRx && !q.contRx && !wrAcc |=> !q.singleRx)
    else $error("single receive not cleared");
  a_ready_clear: assert property (@(posedge clk) disable iff (rst)
    sLastPop |=> (q.fifoCnt == 0) ##1 !q.rxIrq)
    else $error("receive ready stayed after drain");
  a_overrun_blk: assert property (@(posedge clk) disable iff (rst)
    q.overrun && !popRx |=> q.fifoCnt == $past(q.fifoCnt))
    else $error("transfer while overrun set");
  a_err_clear: assert property (@(posedge clk) disable iff (rst)
    !q.contRx |=> !q.overrun)
    else $error("error kept after receive disable");
  a_addr_drop: assert property (@(posedge clk) disable iff (rst)
    q.rxState == usart_pkg::RX_STOP && tick && q.rxPhase && q.rxNinthEn && q.addrDet
      && !q.rxShift[8] && !popRx |=> q.fifoCnt == $past(q.fifoCnt))
    else $error("non-address word accepted");
endmodule // usart_sync_tx

// [sync_slave_model.sv]
/*
  far-side clocked slave that shifts in whatever the port sends.
  assumes the port is clock master and changes data on rising clock.
*/
`timescale 1ns/1ps
module sync_slave_model #(
  // two baud ticks at the bench divisor
  parameter int BIT_CLKS = 8
) (
  // system clock
  input  wire logic clk,
  // pins of the port
  input  wire logic shiftClockOut,
  input  wire logic shiftClockOe_n,
  input  wire logic serialDataOut,
  input  wire logic serialDataOe_n,
  // resolved data wire
  output wire logic dataWire
);
  logic idleBit = 1'b0;
  logic lineQ   = 1'b1;
  logic driveQ  = 1'b0;
  logic bitsQ[$];
  // released line floats: show a changing level, never the last one
  always @(posedge clk) idleBit <= ~idleBit;
  // once the far end owns the line it idles high, as an async sender would
  assign dataWire = !serialDataOe_n ? serialDataOut : (driveQ ? lineQ : idleBit);
  task automatic take_line;
    driveQ <= 1'b1;
    lineQ  <= 1'b1;
  endtask
  // start bit, nine data bits lsb first, two stop bits
  task automatic send_frame(input logic [8:0] w);
    logic [11:0] f;
    f = {2'b11, w, 1'b0};
    for (int i = 0; i < 12; i++) begin
      lineQ <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
  // sample mid-bit, where the port keeps data steady
  always @(negedge shiftClockOut) begin
    if (!shiftClockOe_n && !serialDataOe_n) begin
      bitsQ.push_back(serialDataOut);
    end
  end
endmodule // sync_slave_model

// [usart_sync_master_tx_addr_detect_tb_top.sv]
/*
  self-checking bench for the clocked master transmitter.
  assumes the apb slave answers at once and a 400 ns shift clock.
*/
`timescale 1ns/1ps
module usart_sync_master_tx_addr_detect_tb_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, sck, sckOe_n, sdo, sdoOe_n, dataWire, rxIrq, txIrq;
  logic [7:0]  w;
  int          miscompares = 0, comparisons = 0, n;
  int          expQ[$];
  localparam logic [7:0] RIDX [8] = '{8'h0b, 8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99};
  localparam logic [7:0] RRST [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  usart_sync_tx u_usart_sync_tx (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shiftClockOut(sck), .shiftClockOe_n(sckOe_n), .serialDataIn(dataWire), .serialDataOut(sdo),
    .serialDataOe_n(sdoOe_n), .rxIrqReq(rxIrq), .txIrqReq(txIrq));
  sync_slave_model u_sync_slave_model (.clk(clk), .shiftClockOut(sck), .shiftClockOe_n(sckOe_n),
    .serialDataOut(sdo), .serialDataOe_n(sdoOe_n), .dataWire(dataWire));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one edge first, so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expect_word(input logic [7:0] d, input logic ninth);
    for (int i = 0; i < 8; i++) expQ.push_back(int'(d[i]));
    expQ.push_back(int'(ninth));
  endtask
  task automatic wait_bit(input logic [7:0] idx, input int b, input logic v);
    n = 0;
    do begin
      apb(1'b0, idx, 8'h00);
      n++;
    end while (rd[b] !== v && n < 100);
    if (rd[b] !== v) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  // bounds the whole run at 40000 cycles
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'h03ebb54d));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (RIDX[i]) begin
      apb(1'b0, RIDX[i], 8'h00);
      chk(rd, {24'h0, RRST[i]});
    end
    apb(1'b0, 8'h20, 8'h00);
    chk({31'h0, err}, 32'h1);
    // start order: divisor, mode, port, irq, ninth, enable
    apb(1'b1, 8'h99, 8'h03);
    apb(1'b1, 8'h98, 8'h90);
    apb(1'b1, 8'h18, 8'h80);
    apb(1'b1, 8'h8c, 8'h10);
    chk({31'h0, sckOe_n}, 32'h1);
    apb(1'b1, 8'h98, 8'hd0);
    apb(1'b1, 8'h98, 8'hf1);
    repeat (20) @(posedge clk);
    chk({31'h0, sckOe_n}, 32'h0);
    chk({31'h0, sdoOe_n}, 32'h0);
    chk(u_sync_slave_model.bitsQ.size(), 0);
    w = 8'($urandom);
    apb(1'b1, 8'h19, w);
    expect_word(w, 1'b1);
    apb(1'b0, 8'h0c, 8'h00);
    chk({31'h0, rd[4]}, 32'h1);
    apb(1'b1, 8'h0c, 8'h00);
    apb(1'b0, 8'h0c, 8'h00);
    chk({31'h0, rd[4]}, 32'h1);
    chk({31'h0, txIrq}, 32'h1);
    apb(1'b0, 8'h98, 8'h00);
    chk({31'h0, rd[1]}, 32'h0);
    // new ninth value must only reach the second word
    apb(1'b1, 8'h98, 8'hf0);
    w = 8'($urandom);
    apb(1'b1, 8'h19, w);
    expect_word(w, 1'b0);
    apb(1'b0, 8'h0c, 8'h00);
    chk({31'h0, rd[4]}, 32'h0);
    wait_bit(8'h98, 1, 1'b1);
    chk(u_sync_slave_model.bitsQ.size(), expQ.size());
    foreach (expQ[i]) chk(u_sync_slave_model.bitsQ[i], expQ[i]);
    // abort by clearing transmit enable mid-word
    apb(1'b1, 8'h19, 8'($urandom));
    repeat (12) @(posedge clk);
    apb(1'b1, 8'h98, 8'h90);
    repeat (2) @(posedge clk);
    chk({30'h0, sckOe_n, sdoOe_n}, 32'h3);
    apb(1'b0, 8'h98, 8'h00);
    chk({31'h0, rd[1]}, 32'h1);
    // abort by continuous receive mid-word
    apb(1'b1, 8'h98, 8'hb0);
    apb(1'b1, 8'h19, 8'($urandom));
    repeat (12) @(posedge clk);
    apb(1'b1, 8'h18, 8'h90);
    repeat (2) @(posedge clk);
    chk({30'h0, sckOe_n, sdoOe_n}, 32'h1);
    // software drops transmit enable so data is not driven again
    apb(1'b1, 8'h98, 8'h90);
    apb(1'b1, 8'h18, 8'h80);
    // single receive cuts in, then the transmitter takes the line back
    apb(1'b1, 8'h98, 8'hb0);
    apb(1'b1, 8'h19, 8'($urandom));
    repeat (12) @(posedge clk);
    apb(1'b1, 8'h18, 8'ha0);
    wait_bit(8'h18, 5, 1'b0);
    chk({31'h0, sdoOe_n}, 32'h0);
    apb(1'b1, 8'h98, 8'h90);
    apb(1'b0, 8'h1a, 8'h00);
    apb(1'b0, 8'h0c, 8'h00);
    chk({31'h0, rd[5]}, 32'h0);
    // async 9-bit reception with address detect
    apb(1'b1, 8'h98, 8'h00);
    u_sync_slave_model.take_line();
    apb(1'b1, 8'h8c, 8'h20);
    apb(1'b1, 8'h18, 8'h80);
    apb(1'b1, 8'h18, 8'hc0);
    apb(1'b1, 8'h18, 8'hc8);
    apb(1'b1, 8'h18, 8'hd8);
    w = 8'($urandom);
    u_sync_slave_model.send_frame({1'b0, ~w});
    u_sync_slave_model.send_frame({1'b1, w});
    wait_bit(8'h0c, 5, 1'b1);
    chk({31'h0, rxIrq}, 32'h1);
    apb(1'b0, 8'h18, 8'h00);
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b0, 8'h1a, 8'h00);
    chk(rd, {24'h0, w});
    apb(1'b1, 8'h18, 8'hd0);
    w = 8'($urandom);
    u_sync_slave_model.send_frame({1'b0, w});
    wait_bit(8'h0c, 5, 1'b1);
    apb(1'b0, 8'h1a, 8'h00);
    chk(rd, {24'h0, w});
    apb(1'b0, 8'h0c, 8'h00);
    chk({31'h0, rd[5]}, 32'h0);
    apb(1'b1, 8'h18, 8'h80);
    report_and_stop();
  end
endmodule // usart_sync_master_tx_addr_detect_tb_top
